// ==== core/sbtc_params.svh ====
// constants for the sixteen bit timer counter: offsets, fields, reset values
`ifndef SBTC_PARAMS_SVH
`define SBTC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define SBTC_ADDR_CTRL     4'h0
`define SBTC_ADDR_CNT_LO   4'h1
`define SBTC_ADDR_CNT_HI   4'h2
`define SBTC_ADDR_STATUS   4'h3
`define SBTC_ADDR_MASK     4'h4

// ****************************************
// control register fields
// ****************************************
`define SBTC_CTRL_SRC_HI   7
`define SBTC_CTRL_SRC_LO   6
`define SBTC_CTRL_GATE_EN  5
`define SBTC_CTRL_GATE_POL 4
`define SBTC_CTRL_NSYNC    3
`define SBTC_CTRL_RUN      0

// ****************************************
// status and mask fields
// ****************************************
`define SBTC_ST_OVF        0
`define SBTC_ST_GATE_DONE  1
`define SBTC_ST_WIDTH      2

// ****************************************
// reset values, counter limits and increments
// ****************************************
`define SBTC_CTRL_RST      8'h00
`define SBTC_CNT_RST       16'h0000
`define SBTC_ST_RST        2'h0
`define SBTC_RD_ZERO       8'h00
`define SBTC_CNT_MAX       16'hffff
`define SBTC_CNT_ONE       16'h0001
`define SBTC_DIV_RST       2'h0
`define SBTC_DIV_ONE       2'h1
`define SBTC_DIV_LAST      2'h3

`endif

// ==== core/sbtc_pkg.sv ====
// types shared by the sixteen bit timer counter files
package sbtc_pkg;

  // count clock selection held in the two high control bits
  typedef enum logic [1:0] {
    sbtc_src_icycle = 2'h0,
    sbtc_src_sysosc = 2'h1,
    sbtc_src_ext    = 2'h2,
    sbtc_src_rsvd   = 2'h3
  } sbtc_src_t;

  typedef logic [7:0]  sbtc_byte_t;
  typedef logic [15:0] sbtc_count_t;

endpackage : sbtc_pkg

// ==== core/sbtc_tick_if.sv ====
// tick bundle passed from the edge selector to the counter core
`timescale 1ns/1ps
interface sbtc_tick_if;
  logic tick;      // one counting event this cycle
  logic gate_ok;   // gate lets counting pass
  logic async_on;  // counting on unsynchronised external path
  modport src (output tick, output gate_ok, output async_on);
  modport dst (input tick, input gate_ok, input async_on);
endinterface : sbtc_tick_if

// ==== core/sbtc_tick_sel.sv ====
// selects the count source and resolves the gate at full clock rate
`timescale 1ns/1ps
`include "sbtc_params.svh"
module sbtc_tick_sel (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // configuration
  input  wire sbtc_pkg::sbtc_src_t src,
  input  wire logic            nsync,
  input  wire logic            gate_en,
  input  wire logic            gate_pol,
  // pins
  input  wire logic            ext_count_clock_pin,
  input  wire logic            gate_pin,
  // to core
  sbtc_tick_if.src             tk
);
  import sbtc_pkg::*;

  logic [1:0] div;
  logic       ext_q;
  logic       gate_q;

  // ****************************************
  // instruction cycle divider and pin history
  // ****************************************
  // divider gives a one-cycle enable every fourth clock
  always_ff @(posedge clk) begin
    if (reset) begin
      div    <= `SBTC_DIV_RST;
      ext_q  <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      div    <= div + `SBTC_DIV_ONE;
      ext_q  <= ext_count_clock_pin;
      gate_q <= gate_pin;
    end
  end

  // ****************************************
  // tick selection
  // ****************************************
  // gate sampled every clock, not per instruction cycle, so it resolves at full rate
  always_comb begin
    tk.gate_ok  = !gate_en || (gate_q == gate_pol); // RQ3
    tk.async_on = (src == sbtc_src_ext) && nsync;
    unique case (src)
      sbtc_src_sysosc: tk.tick = 1'b1;                          // RQ1 RQ3
      sbtc_src_ext:    tk.tick = ext_count_clock_pin && !ext_q; // RQ2
      sbtc_src_icycle: tk.tick = (div == `SBTC_DIV_LAST);
      default:         tk.tick = 1'b0;
    endcase
  end

endmodule : sbtc_tick_sel

// ==== core/sbtc_timer.sv ====
// sixteen bit timer counter top with register port and interrupt
// ****************************************
// Summary of operation
// (RQ1) source 01 counts system clock
// (RQ2) source 10, bit3 clear counts pin edges
// (RQ3) gate acts at full clock rate
// (RQ4) count write never sets overflow flag
// (RQ5) enable or mode switch never sets flag
// (RQ6) count never cleared by spurious flag
// (RQ7) count reads have no side effects
// (RQ8) run bit stops and resumes counting
// (RQ9) flag independent, irq needs flag and enable
// (RQ10) software waits after async count write
// (RQ11) software prefers synchronous counting
// (RQ12) byte writes load halves, reads show count
// ****************************************
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sbtc_params.svh"
module sbtc_timer (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [3:0]        addr,
  input  wire sbtc_pkg::sbtc_byte_t wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output sbtc_pkg::sbtc_byte_t   rdata,
  // pins
  input  wire logic              ext_count_clock_pin,
  input  wire logic              gate_pin,
  // interrupt and status
  output logic                   irq,
  output logic                   overflow_flag
);
  import sbtc_pkg::*;

  sbtc_tick_if tk ();

  sbtc_byte_t                  timer_control_reg;
  sbtc_count_t                 count;
  logic [`SBTC_ST_WIDTH-1:0]   status;
  logic [`SBTC_ST_WIDTH-1:0]   mask;
  logic                        gate_prev;
  logic                        inc;
  logic                        wrap;
  logic                        gate_fall;
  logic [`SBTC_ST_WIDTH-1:0]   ev;

  // decode helper used by every register write; the read port decodes addr in its own case
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // ****************************************
  // count source
  // ****************************************
  sbtc_tick_sel u_sel (
    .clk                 (clk),
    .reset               (reset),
    .src                 (sbtc_src_t'(timer_control_reg[`SBTC_CTRL_SRC_HI:`SBTC_CTRL_SRC_LO])),
    .nsync               (timer_control_reg[`SBTC_CTRL_NSYNC]),
    .gate_en             (timer_control_reg[`SBTC_CTRL_GATE_EN]),
    .gate_pol            (timer_control_reg[`SBTC_CTRL_GATE_POL]),
    .ext_count_clock_pin (ext_count_clock_pin),
    .gate_pin            (gate_pin),
    .tk                  (tk.src)
  );

  // ****************************************
  // increment and overflow detect
  // ****************************************
  // overflow only from a real wrap; writes, enables and mode changes carry no overflow event
  assign inc       = timer_control_reg[`SBTC_CTRL_RUN] && tk.tick && tk.gate_ok; // RQ8
  assign wrap      = inc && (count == `SBTC_CNT_MAX)
                     && !(wr && (hit(addr, `SBTC_ADDR_CNT_LO)
                     || hit(addr, `SBTC_ADDR_CNT_HI))); // RQ4 RQ5
  assign gate_fall = timer_control_reg[`SBTC_CTRL_GATE_EN] && gate_prev && !tk.gate_ok;
  assign ev        = {gate_fall, wrap};

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_control_reg <= `SBTC_CTRL_RST;
    end else if (wr && hit(addr, `SBTC_ADDR_CTRL)) begin
      timer_control_reg <= wdata; // RQ5
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // a count byte write takes priority over a coinciding tick; the tick is dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= `SBTC_CNT_RST;
    end else if (wr && hit(addr, `SBTC_ADDR_CNT_LO)) begin
      count[7:0] <= wdata; // RQ12
    end else if (wr && hit(addr, `SBTC_ADDR_CNT_HI)) begin
      count[15:8] <= wdata; // RQ12
    end else if (inc) begin
      count <= count + `SBTC_CNT_ONE; // RQ1 RQ2 RQ6 RQ8
    end
  end

  // gate history for the gate-closed event
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_prev <= 1'b0;
    end else begin
      gate_prev <= tk.gate_ok;
    end
  end

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  // set wins over write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= `SBTC_ST_RST;
    end else begin
      for (int i = 0; i < `SBTC_ST_WIDTH; i++) begin
        if (ev[i]) begin
          status[i] <= 1'b1; // RQ9
        end else if (wr && hit(addr, `SBTC_ADDR_STATUS) && wdata[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= `SBTC_ST_RST;
    end else if (wr && hit(addr, `SBTC_ADDR_MASK)) begin
      mask <= wdata[`SBTC_ST_WIDTH-1:0];
    end
  end

  // registered outputs lag the status by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq           <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      irq           <= |(status & mask); // RQ9
      overflow_flag <= status[`SBTC_ST_OVF];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // reads are pure: nothing but rdata changes
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= `SBTC_RD_ZERO;
    end else if (rd) begin
      unique case (addr)
        `SBTC_ADDR_CTRL:   rdata <= timer_control_reg;
        `SBTC_ADDR_CNT_LO: rdata <= count[7:0];  // RQ7 RQ12
        `SBTC_ADDR_CNT_HI: rdata <= count[15:8]; // RQ7 RQ12
        `SBTC_ADDR_STATUS: rdata <= {6'h00, status};
        `SBTC_ADDR_MASK:   rdata <= {6'h00, mask};
        default:           rdata <= `SBTC_RD_ZERO;
      endcase
    end else begin
      rdata <= `SBTC_RD_ZERO;
    end
  end

endmodule : sbtc_timer

// ==== tb/sbtc_ext_src.sv ====
// external count clock source model driving the timer count pin
`timescale 1ns/1ps
module sbtc_ext_src (
  // clock and control
  input  wire logic clk,
  input  wire logic go,
  // pin
  output logic      pin
);
  logic [1:0] ph;
  initial begin
    ph  = 2'h0;
    pin = 1'b0;
  end
  // one rising edge every four clocks; rests low between bursts
  always @(posedge clk) begin
    ph  <= go ? ph + 2'h1 : 2'h0;
    pin <= go & ph[1];
  end
endmodule : sbtc_ext_src

// ==== tb/sbtc_timer_assertions.sv ====
// port checks for the timer counter, bound to its top
`timescale 1ns/1ps
module sbtc_timer_assertions (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // register port
  input wire logic [3:0]           addr,
  input wire sbtc_pkg::sbtc_byte_t wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire sbtc_pkg::sbtc_byte_t rdata,
  // pins and outputs
  input wire logic                 ext_count_clock_pin,
  input wire logic                 gate_pin,
  input wire logic                 irq,
  input wire logic                 overflow_flag
);
  import sbtc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] mask_q;
  logic       run_q;
  // mirrors of mask and run bit, since neither is visible at the ports
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= 2'h0;
      run_q  <= 1'b0;
    end else if (wr && addr == 4'h4) begin
      mask_q <= wdata[1:0];
    end else if (wr && addr == 4'h0) begin
      run_q  <= wdata[0];
    end
  end
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  AST_RD_UNMAPPED: assert property ($past(rd) && $past(addr) > 4'h4 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAG_W1C: assert property ($fell(overflow_flag) |->
    $past(wr, 2) && $past(addr, 2) == 4'h3 && $past(wdata[0], 2))
    else $error("flag dropped without clear");
  AST_WR_NO_FLAG: assert property ($rose(overflow_flag) |->
    !($past(wr, 2) && $past(addr, 2) inside {4'h1, 4'h2}))
    else $error("count write set flag");
  AST_STOP_NO_FLAG: assert property ($rose(overflow_flag) |->
    $past(run_q, 2) || $past(run_q, 3) || $past(run_q, 4))
    else $error("flag while stopped");
  AST_IRQ_MASKED: assert property (irq |-> $past(mask_q) != 2'h0)
    else $error("irq while masked");
  AST_OVF_IRQ: assert property (overflow_flag && $past(mask_q[0]) |-> irq)
    else $error("irq missing");
  AST_IRQ_FLAG: assert property (!overflow_flag && $past(mask_q) == 2'h1 |-> !irq)
    else $error("irq without flag");
  COV_FLAG: cover property ($rose(overflow_flag));
  COV_IRQ: cover property ($rose(irq));
  COV_CLR: cover property ($fell(overflow_flag));
endmodule : sbtc_timer_assertions
bind sbtc_timer sbtc_timer_assertions u_chk (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_count_clock_pin(ext_count_clock_pin),
  .gate_pin(gate_pin), .irq(irq), .overflow_flag(overflow_flag));

// ==== tb/testbench.sv ====
// self-checking bench for the timer counter
`timescale 1ns/1ps
module testbench;
  import sbtc_pkg::*;
  logic [3:0] addr = 4'h0;
  sbtc_byte_t wdata = 8'h00;
  sbtc_byte_t rdata, v0, v1;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       go = 1'b0;
  logic       gate = 1'b0;
  logic       irq, overflow_flag, pin;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         n_edge = 0;
  sbtc_timer dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_count_clock_pin(pin), .gate_pin(gate), .irq(irq),
    .overflow_flag(overflow_flag));
  sbtc_ext_src u_src (.clk(clk), .go(go), .pin(pin));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge pin) n_edge++;
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wreg(input logic [3:0] a, input sbtc_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output sbtc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rreg
  task automatic t_sys();
    wreg(4'h2, 8'hff);
    wreg(4'h1, 8'hf0);
    rreg(4'h1, v0);
    check("cnt_lo", v0, 16'h00f0);
    check("flag", overflow_flag, 16'h0000);
    wreg(4'h0, 8'h41);
    repeat (20) @(posedge clk);
    wreg(4'h0, 8'h40);
    rreg(4'h2, v0);
    check("cnt_hi", v0, 16'h0000);
    check("irq", irq, 16'h0000);
    rreg(4'h1, v0);
    check("sys_cnt", v0, 16'h0006);
    repeat (4) @(posedge clk);
    rreg(4'h1, v1);
    check("stopped", v1, v0);
    check("flag", overflow_flag, 16'h0001);
    wreg(4'h4, 8'h01);
    repeat (2) @(negedge clk);
    check("irq", irq, 16'h0001);
    wreg(4'h3, 8'h01);
    repeat (2) @(negedge clk);
    check("irq", irq, 16'h0000);
    wreg(4'h0, 8'h41);
    wreg(4'h0, 8'h40);
    rreg(4'h1, v1);
    check("resume", v1, v0 + 8'h02);
    rreg(4'hf, v0);
    check("unmapped", v0, 16'h0000);
    $display("test t_sys done");
  endtask : t_sys
  task automatic t_ext();
    wreg(4'h1, 8'h00);
    wreg(4'h0, 8'h81);
    n_edge = 0;
    go <= 1'b1;
    repeat (40) @(posedge clk);
    go <= 1'b0;
    rreg(4'h0, v0);
    check("ctrl", v0, 16'h0081);
    rreg(4'h1, v0);
    check("ext_cnt", v0, n_edge[7:0]);
    wreg(4'h0, 8'h89);
    go <= 1'b1;
    repeat (12) @(posedge clk);
    go <= 1'b0;
    rreg(4'h0, v0);
    check("ctrl", v0, 16'h0089);
    check("flag", overflow_flag, 16'h0000);
    rreg(4'h1, v1);
    check("async_cnt", v1, n_edge[7:0]);
    $display("test t_ext done");
  endtask : t_ext
  // async mode: count write lands on the very edge that would wrap 0xffff
  task automatic t_async();
    wreg(4'h0, 8'h88);
    wreg(4'h2, 8'hff);
    wreg(4'h1, 8'hff);
    wreg(4'h0, 8'h89);
    go <= 1'b1;
    repeat (2) @(posedge clk);
    wreg(4'h1, 8'h10);
    // two full pin periods plus two cycles before touching flag or mask
    repeat (10) @(posedge clk);
    go <= 1'b0;
    rreg(4'h1, v0);
    check("async_lo", v0, 16'h0012);
    rreg(4'h2, v1);
    check("async_hi", v1, 16'h00ff);
    check("flag", overflow_flag, 16'h0000);
    check("irq", irq, 16'h0000);
    wreg(4'h3, 8'h01);
    wreg(4'h4, 8'h01);
    // a genuine wrap on the async path still flags
    wreg(4'h1, 8'hfe);
    go <= 1'b1;
    repeat (12) @(posedge clk);
    go <= 1'b0;
    rreg(4'h1, v0);
    check("wrap_lo", v0, 16'h0001);
    check("flag", overflow_flag, 16'h0001);
    check("irq", irq, 16'h0001);
    $display("test t_async done");
  endtask : t_async
  // three open gate cycles give three counts only at full rate
  task automatic t_gate();
    wreg(4'h0, 8'h71);
    wreg(4'h3, 8'h03);
    wreg(4'h1, 8'h00);
    wreg(4'h2, 8'h00);
    gate <= 1'b1;
    repeat (3) @(posedge clk);
    gate <= 1'b0;
    rreg(4'h1, v0);
    check("gate_cnt", v0, 16'h0003);
    rreg(4'h3, v0);
    check("gate_event", v0, 16'h0002);
    check("irq", irq, 16'h0000);
    $display("test t_gate done");
  endtask : t_gate
  // eight running cycles: two counts at clk/4, none with no source
  task automatic t_src();
    wreg(4'h0, 8'h00);
    wreg(4'h1, 8'h00);
    wreg(4'h0, 8'h01);
    repeat (6) @(posedge clk);
    wreg(4'h0, 8'h00);
    rreg(4'h1, v0);
    check("icycle_cnt", v0, 16'h0002);
    wreg(4'h0, 8'hc1);
    repeat (6) @(posedge clk);
    wreg(4'h0, 8'hc0);
    rreg(4'h1, v1);
    check("none_cnt", v1, 16'h0002);
    $display("test t_src done");
  endtask : t_src
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_sys();
    t_ext();
    t_async();
    t_gate();
    t_src();
    finish_test();
  end
endmodule : testbench
